// ### eeprom_bus_slave.sv
// Purpose: Two-wire bus slave front end of a small serial EEPROM.
// Assumes: clk_in runs at least ten times faster than the bus clock.
// Notes:   Memory array, write cycle and write protection live outside this block.

`timescale 1ns/1ps

// How it works
// R1 - Sample on SCL rise, drive on fall
// R2 - Bytes shift MSB first, one bit per clock
// R3 - Nine SCL cycles per byte, no gaps
// R4 - Master changes SDA only while SCL low
// R5 - SDA fall with SCL high is Start
// R6 - SDA rise with SCL high is Stop
// R7 - Ignore bus and never drive before Start
// R8 - Repeated Start begins a new command
// R9 - Release after eighth bit, ack holds low
// R10 - Receiver releases SDA after ninth cycle
// R11 - Master NACK while sending ends in standby
// R12 - Standby on reset, Stop, write end, mismatch
// R13 - Master recovers bus with Start, nine clocks
// R14 - First byte upper nibble matches type field
// R15 - Address bits 3..1 match the straps
// R16 - Floating straps read zero
// R17 - Bit 0 one means read
// R18 - Ack on match, else release and standby
// R19 - Word address follows; small part drops top
// R20 - Pages of eight bytes, 16 or 32
// R21 - Bus idle when SCL and SDA high
// R22 - No limit on bytes per transfer
// R23 - Open drain, only ever pulls low
module eeprom_bus_slave
    import eeprom_slave_pkg::*;
#(
    parameter int         ADDR_W   = 8,
    parameter logic [3:0] DEV_TYPE = 4'h5
) (
    input  wire logic                        clk_in,
    input  wire logic                        srst_in,
    input  wire logic                        scl_in,
    input  wire logic                        sda_in,
    output logic                             sda_out,
    output logic                             sda_oe_n_out,
    input  wire logic                        strap_addr_bit_hi_in,
    input  wire logic                        strap_addr_bit_mid_in,
    input  wire logic                        strap_addr_bit_lo_in,
    input  wire logic [7:0]                  rd_data_in,
    input  wire logic                        write_done_in,
    output logic                             rd_next_out,
    output logic                             wr_valid_out,
    output logic [7:0]                       wr_data_out,
    output logic [ADDR_W-1:0]                word_addr_out,
    output logic [ADDR_W-eeprom_slave_pkg::PAGE_BITS-1:0] page_out,
    output logic                             rw_out,
    output logic                             selected_out,
    output logic                             standby_out,
    output logic                             bus_idle_out
);

    // DEV_TYPE default is an arbitrary value; set it per product.

    // ==========================================================
    // Declarations
    // ==========================================================
    link_state_t  state_reg;
    bus_pins_t    pins_s;
    logic [1:0]   pins_low_s;
    bus_pins_t    pins_d_reg;
    bus_events_t  ev;
    logic [2:0]   strap_s;
    logic         sampled_bit;
    logic         bit_toggle;
    logic         toggle_s;
    logic         toggle_d_reg;
    logic [3:0]   bit_cnt_reg;
    logic [7:0]   shift_reg;
    logic [7:0]   tx_reg;
    logic [7:0]   byte_next;
    logic         ack_pend_reg;
    logic         drive_reg;
    logic         addr_match;

    // ==========================================================
    // Link clock domain and synchronisers
    // ==========================================================
    scl_bit_sampler u_sampler (
        .scl_clk_in (scl_in),
        .rst_in     (srst_in),
        .sda_in     (sda_in),
        .bit_out    (sampled_bit),
        .toggle_out (bit_toggle)
    );

    bit_sync #(.W(1)) u_toggle_sync (
        .clk_in  (clk_in),
        .srst_in (srst_in),
        .d_in    (bit_toggle),
        .q_out   (toggle_s)
    );

    // The synchroniser clears to zero, so the pins pass through it inverted.
    // Out of reset they then read as an idle high bus and no false edge follows.
    bit_sync #(.W(2)) u_pin_sync (
        .clk_in  (clk_in),
        .srst_in (srst_in),
        .d_in    ({~scl_in, ~sda_in}),
        .q_out   (pins_low_s)
    );

    assign pins_s = bus_pins_t'(~pins_low_s);

    // Floating straps are pulled down outside, so they arrive here as zero.
    bit_sync #(.W(3)) u_strap_sync (
        .clk_in  (clk_in),
        .srst_in (srst_in),
        .d_in    ({strap_addr_bit_hi_in, strap_addr_bit_mid_in, strap_addr_bit_lo_in}), // [R16]
        .q_out   (strap_s)
    );

    // ==========================================================
    // Bus event detection
    // ==========================================================
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pins_d_reg   <= '{scl: 1'b1, sda: 1'b1};
            toggle_d_reg <= 1'b0;
        end else begin
            pins_d_reg   <= pins_s;
            toggle_d_reg <= toggle_s;
        end
    end

    always_comb begin
        ev.start = pins_s.scl & pins_d_reg.scl & pins_d_reg.sda & ~pins_s.sda; // [R5]
        ev.stop  = pins_s.scl & pins_d_reg.scl & ~pins_d_reg.sda & pins_s.sda; // [R6]
        ev.rise  = toggle_s ^ toggle_d_reg;                                      // [R1]
        ev.fall  = pins_d_reg.scl & ~pins_s.scl;
    end

    assign byte_next  = {shift_reg[6:0], sampled_bit}; // [R2]
    assign addr_match = (byte_next[TYPE_MSB:TYPE_LSB] == DEV_TYPE) &&   // [R14]
                        (byte_next[STRAP_MSB:STRAP_LSB] == strap_s);    // [R15]

    // ==========================================================
    // Protocol state
    // ==========================================================
    // Start wins over everything else so that a repeated Start always
    // realigns the byte framing, whatever the previous command was doing.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_reg    <= ST_IDLE; // [R12]
            bit_cnt_reg  <= CNT_RST;
            shift_reg    <= BYTE_RST;
            ack_pend_reg <= 1'b0;
        end else if (ev.start) begin
            state_reg    <= ST_ADDR; // [R5] [R8]
            bit_cnt_reg  <= CNT_RST;
            ack_pend_reg <= 1'b0;
        end else if (ev.stop || write_done_in) begin
            state_reg    <= ST_IDLE; // [R6] [R12]
            bit_cnt_reg  <= CNT_RST;
            ack_pend_reg <= 1'b0;
        end else if (ev.fall) begin
            ack_pend_reg <= 1'b0;
        end else if (ev.rise && state_reg != ST_IDLE) begin // [R7]
            if (bit_cnt_reg == ACK_SLOT_CNT) begin
                bit_cnt_reg <= CNT_RST; // [R3]
                unique case (state_reg)
                    ST_ADDR:    state_reg <= shift_reg[RW_BIT] ? ST_DATA_TX : ST_WORD; // [R17] [R19]
                    ST_WORD:    state_reg <= ST_DATA_RX;
                    ST_DATA_RX: state_reg <= ST_DATA_RX; // [R22]
                    ST_DATA_TX: state_reg <= sampled_bit ? ST_IDLE : ST_DATA_TX; // [R11]
                    ST_IDLE:    state_reg <= ST_IDLE;
                endcase
            end else begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                if (state_reg != ST_DATA_TX) begin
                    shift_reg <= byte_next; // [R2]
                end
                if (bit_cnt_reg == LAST_DATA_CNT && state_reg != ST_DATA_TX) begin
                    if (state_reg == ST_ADDR && !addr_match) begin
                        state_reg <= ST_IDLE; // [R18] [R12]
                    end else begin
                        ack_pend_reg <= 1'b1; // [R18] [R9]
                    end
                end
            end
        end
    end

    // ==========================================================
    // Captured fields and user-side strobes
    // ==========================================================
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rw_out        <= 1'b0;
            word_addr_out <= '0;
            page_out      <= '0;
            wr_data_out   <= BYTE_RST;
            wr_valid_out  <= 1'b0;
        end else begin
            wr_valid_out <= 1'b0;
            if (ev.rise && !ev.start && !ev.stop && bit_cnt_reg == LAST_DATA_CNT) begin
                unique case (state_reg)
                    ST_ADDR: begin
                        if (addr_match) begin
                            rw_out <= byte_next[RW_BIT]; // [R17]
                        end
                    end
                    ST_WORD: begin
                        word_addr_out <= byte_next[ADDR_W-1:0]; // [R19]
                        page_out      <= byte_next[ADDR_W-1:PAGE_BITS]; // [R20]
                    end
                    ST_DATA_RX: begin
                        wr_data_out  <= byte_next;
                        wr_valid_out <= 1'b1;
                    end
                    ST_DATA_TX, ST_IDLE: begin
                    end
                endcase
            end
        end
    end

    // Next read byte is taken after the address ack and after each master ack.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tx_reg      <= BYTE_RST;
            rd_next_out <= 1'b0;
        end else begin
            rd_next_out <= 1'b0;
            if (ev.rise && !ev.start && !ev.stop && bit_cnt_reg == ACK_SLOT_CNT &&
                ((state_reg == ST_ADDR && shift_reg[RW_BIT]) ||
                 (state_reg == ST_DATA_TX && !sampled_bit))) begin
                tx_reg      <= rd_data_in;
                rd_next_out <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Open-drain data output
    // ==========================================================
    // The line only ever changes on a falling bus clock; a Stop or Start is
    // only legal while the slave has released, so nothing is forced there.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            drive_reg <= 1'b0;
        end else if (ev.fall) begin // [R1]
            if (ack_pend_reg) begin
                drive_reg <= 1'b1; // [R9]
            end else if (state_reg == ST_DATA_TX && bit_cnt_reg <= LAST_DATA_CNT) begin
                drive_reg <= ~tx_reg[3'(LAST_DATA_CNT - bit_cnt_reg)]; // [R2]
            end else begin
                drive_reg <= 1'b0; // [R10] [R9]
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            sda_out      <= 1'b0;
            sda_oe_n_out <= 1'b1;
        end else begin
            sda_out      <= 1'b0; // [R23]
            sda_oe_n_out <= ~drive_reg; // [R23]
        end
    end

    // ==========================================================
    // Status outputs
    // ==========================================================
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            standby_out  <= 1'b1;
            selected_out <= 1'b0;
            bus_idle_out <= 1'b1;
        end else begin
            standby_out  <= (state_reg == ST_IDLE); // [R12]
            selected_out <= (state_reg == ST_WORD) || (state_reg == ST_DATA_RX) ||
                            (state_reg == ST_DATA_TX);
            bus_idle_out <= pins_s.scl & pins_s.sda; // [R21]
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    sequence s_last_rx_bit;
        ev.rise && !ev.start && !ev.stop && bit_cnt_reg == LAST_DATA_CNT &&
        state_reg != ST_IDLE && state_reg != ST_DATA_TX;
    endsequence

    sequence s_master_nack;
        ev.rise && !ev.start && !ev.stop && state_reg == ST_DATA_TX &&
        bit_cnt_reg == ACK_SLOT_CNT && sampled_bit;
    endsequence

    a_drive_on_fall: assert property (@(posedge clk_in) disable iff (srst_in)
        $changed(drive_reg) |-> $past(ev.fall)) // [R1]
        else $error("Data line changed away from a bus clock fall.");

    a_count_bound: assert property (@(posedge clk_in) disable iff (srst_in)
        bit_cnt_reg <= ACK_SLOT_CNT) // [R3]
        else $error("Bit counter passed the acknowledge slot.");

    a_start_wakes: assert property (@(posedge clk_in) disable iff (srst_in)
        ev.start |=> state_reg == ST_ADDR && bit_cnt_reg == CNT_RST) // [R5]
        else $error("Start did not open a new address byte.");

    a_stop_sleeps: assert property (@(posedge clk_in) disable iff (srst_in)
        ev.stop && !ev.start |=> state_reg == ST_IDLE ##1 standby_out) // [R6]
        else $error("Stop did not return to standby.");

    a_idle_quiet: assert property (@(posedge clk_in) disable iff (srst_in)
        state_reg == ST_IDLE && !drive_reg |=> !drive_reg) // [R7]
        else $error("Data line pulled while in standby.");

    a_ack_on_match: assert property (@(posedge clk_in) disable iff (srst_in)
        s_last_rx_bit ##0 (state_reg == ST_ADDR && addr_match) |=> ack_pend_reg) // [R18]
        else $error("Matching address was not acknowledged.");

    a_mismatch_idle: assert property (@(posedge clk_in) disable iff (srst_in)
        s_last_rx_bit ##0 (state_reg == ST_ADDR && !addr_match) |=> state_reg == ST_IDLE && !ack_pend_reg) // [R18]
        else $error("Address mismatch did not go to standby.");

    a_ack_drives: assert property (@(posedge clk_in) disable iff (srst_in)
        ack_pend_reg && ev.fall && !ev.start && !ev.stop |=> drive_reg ##1 !sda_oe_n_out) // [R9]
        else $error("Acknowledge was not driven low at the fall.");

    a_nack_ends: assert property (@(posedge clk_in) disable iff (srst_in)
        s_master_nack |=> state_reg == ST_IDLE) // [R11]
        else $error("Master nack did not end the read.");

    a_rw_capture: assert property (@(posedge clk_in) disable iff (srst_in)
        s_last_rx_bit ##0 (state_reg == ST_ADDR && addr_match) |=> rw_out == $past(sampled_bit)) // [R17]
        else $error("Direction flag not taken from bit zero.");

    a_only_low: assert property (@(posedge clk_in) disable iff (srst_in)
        !sda_out) // [R23]
        else $error("Data output tried to drive high.");

    a_idle_level: assert property (@(posedge clk_in) disable iff (srst_in)
        bus_idle_out |-> $past(pins_s.scl) && $past(pins_s.sda)) // [R21]
        else $error("Bus idle shown while a line was low.");

endmodule // eeprom_bus_slave

// ### eeprom_slave_pkg.sv
// Purpose: Shared constants and types for the two-wire EEPROM bus slave front end.
// Assumes: The bus clock is far slower than the system clock.
// Notes:   Field positions refer to the device address byte and the word address byte.

package eeprom_slave_pkg;

    // ==========================================================
    // Byte framing
    // ==========================================================
    localparam int            BYTE_BITS     = 8;
    localparam logic [3:0]    LAST_DATA_CNT = 4'h7;
    localparam logic [3:0]    ACK_SLOT_CNT  = 4'h8;

    // ==========================================================
    // Device address byte fields
    // ==========================================================
    localparam int            TYPE_MSB      = 7;
    localparam int            TYPE_LSB      = 4;
    localparam int            STRAP_MSB     = 3;
    localparam int            STRAP_LSB     = 1;
    localparam int            RW_BIT        = 0;

    // ==========================================================
    // Memory organisation
    // ==========================================================
    localparam int            PAGE_BITS     = 3;
    localparam int            WORD_ADDR_MAX = 8;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [3:0]    CNT_RST       = 4'h0;
    localparam logic [7:0]    BYTE_RST      = 8'h00;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_ADDR    = 3'b001,
        ST_WORD    = 3'b010,
        ST_DATA_RX = 3'b011,
        ST_DATA_TX = 3'b100
    } link_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } bus_pins_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
    } bus_events_t;

endpackage

// ### bit_sync.sv
// Purpose: Two flip-flop synchroniser for levels entering the system clock domain.
// Assumes: Each bit is an independent level.
// Notes:   Only the second stage may be read by other logic.

`timescale 1ns/1ps

module bit_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         srst_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);

    logic [W-1:0] meta_reg;

    // ==========================================================
    // Two stages
    // ==========================================================
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            meta_reg <= '0;
            q_out    <= '0;
        end else begin
            meta_reg <= d_in;
            q_out    <= meta_reg;
        end
    end

endmodule // bit_sync

// ### scl_bit_sampler.sv
// Purpose: Captures the data line on each rising edge of the bus clock.
// Assumes: The bus clock may stop between frames.
// Notes:   Each capture flips a toggle so the system domain sees one event per edge.

`timescale 1ns/1ps

module scl_bit_sampler (
    input  wire logic scl_clk_in,
    input  wire logic rst_in,
    input  wire logic sda_in,
    output logic      bit_out,
    output logic      toggle_out
);

    // ==========================================================
    // Rising edge capture
    // ==========================================================
    // The held bit stays stable for a whole bus clock period, which is long
    // enough for the toggle to cross before the next capture overwrites it.
    always_ff @(posedge scl_clk_in or posedge rst_in) begin
        if (rst_in) begin
            bit_out    <= 1'b1;
            toggle_out <= 1'b0;
        end else begin
            bit_out    <= sda_in;
            toggle_out <= ~toggle_out;
        end
    end

endmodule // scl_bit_sampler

// ### bus_master_model.sv
// Purpose: Behavioural two-wire bus master that drives the bus clock and pulls the data line low.
// Assumes: The data line has a pull-up, so a released line reads high.
// Notes:   The bus clock stands still between calls, and each call except clock_low and stop_cond runs whole bus clock cycles.

`timescale 1ns/1ps

module bus_master_model #(
    parameter real QTR = 31.25
) (
    output logic      scl_out,
    output logic      sda_low_out,
    input  wire logic sda_in
);
    // ==========================================================
    // Idle bus
    // ==========================================================
    initial begin
        scl_out     = 1'b1;
        sda_low_out = 1'b0;
    end

    // ==========================================================
    // Bus cycles
    // ==========================================================
    // Leaves the idle bus by lowering the clock alone, so no Start is formed.
    task automatic clock_low();
        #(QTR) scl_out = 1'b0;
    endtask

    // Data moves only in the middle of the low phase, so no bit can pose as a Start or Stop.
    task automatic bit_cycle(input logic val, output logic seen);
        #(QTR) sda_low_out = ~val;
        #(QTR) scl_out = 1'b1;
        #(QTR) seen = sda_in;
        #(QTR) scl_out = 1'b0;
    endtask

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i], s);
        end
        bit_cycle(1'b1, ack);
    endtask

    task automatic get_byte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, s);
            b[i] = s;
        end
        bit_cycle(nack, s);
    endtask

    task automatic start_cond();
        #(QTR) sda_low_out = 1'b0;
        #(QTR) scl_out = 1'b1;
        #(QTR) sda_low_out = 1'b1;
        #(QTR) scl_out = 1'b0;
    endtask

    task automatic stop_cond();
        #(QTR) sda_low_out = 1'b1;
        #(QTR) scl_out = 1'b1;
        #(QTR) sda_low_out = 1'b0;
        #(QTR);
    endtask
endmodule // bus_master_model

// ### test_eeprom_bus_slave.sv
// Purpose: Self-checking bench for the two-wire EEPROM bus slave front end.
// Assumes: The bus clock runs at 125 ns per cycle, unrelated in phase to the system clock.
// Notes:   Read data advances by a fixed step on every capture strobe.

`timescale 1ns/1ps

module test_eeprom_bus_slave;
    import eeprom_slave_pkg::*;
    localparam logic [3:0] TYPE_ID = 4'h5; // Arbitrary type field value.
    localparam int         LIMIT   = 30000;

    logic       clk_in = 1'b0;
    logic       srst_in = 1'b1;
    logic       scl, sda_low, sda_wire, sda_out, sda_oe_n, ack;
    logic [2:0] strap = 3'b101;
    logic       write_done = 1'b0;
    logic       rd_next, wr_valid, rw, selected, standby, bus_idle;
    logic [7:0] wr_data, word_addr, rd_idx, wr_cnt, rd_data, b;
    logic [4:0] page;
    int         failures = 0;
    int         num_checks = 0;
    int         cycles = 0;

    // ==========================================================
    // Clock, wire and bookkeeping
    // ==========================================================
    always #2.5 clk_in = ~clk_in;
    assign sda_wire = ~(sda_low | (~sda_oe_n & ~sda_out));
    assign rd_data  = 8'h3c + rd_idx * 8'h51;

    always @(posedge clk_in) begin
        if (srst_in) begin
            wr_cnt <= 8'h00;
            rd_idx <= 8'h00;
        end else begin
            if (wr_valid === 1'b1) wr_cnt <= wr_cnt + 8'h01;
            if (rd_next === 1'b1) rd_idx <= rd_idx + 8'h01;
        end
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            final_report();
        end
    end

    bus_master_model i_master (.scl_out(scl), .sda_low_out(sda_low), .sda_in(sda_wire));

    eeprom_bus_slave #(.ADDR_W(8), .DEV_TYPE(TYPE_ID)) i_dut (
        .clk_in(clk_in), .srst_in(srst_in), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe_n_out(sda_oe_n),
        .strap_addr_bit_hi_in(strap[2]), .strap_addr_bit_mid_in(strap[1]), .strap_addr_bit_lo_in(strap[0]),
        .rd_data_in(rd_data), .write_done_in(write_done), .rd_next_out(rd_next),
        .wr_valid_out(wr_valid), .wr_data_out(wr_data), .word_addr_out(word_addr),
        .page_out(page), .rw_out(rw), .selected_out(selected), .standby_out(standby),
        .bus_idle_out(bus_idle)
    );

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Registered outputs trail the bus by a few system clocks.
    task automatic settle();
        repeat (6) @(posedge clk_in);
        #1;
    endtask

    task automatic dev_addr(input logic [3:0] t, input logic [2:0] a, input logic dir);
        i_master.start_cond();
        i_master.put_byte({t, a, dir}, ack);
        settle();
    endtask

    task automatic final_report();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    initial begin
        repeat (2) @(posedge clk_in);
        #1 srst_in = 1'b0;
        settle();
        check("standby", 8'h01, 8'(standby));
        check("bus_idle", 8'h01, 8'(bus_idle));
        check("oe_n", 8'h01, 8'(sda_oe_n));
        i_master.clock_low();
        i_master.put_byte({TYPE_ID, 3'b101, 1'b0}, ack);
        settle();
        check("ack_no_start", 8'h01, 8'(ack));
        check("selected", 8'h00, 8'(selected));
        i_master.start_cond();
        settle();
        check("bus_idle", 8'h00, 8'(bus_idle));
        i_master.put_byte({TYPE_ID, 3'b101, 1'b0}, ack);
        settle();
        check("ack_addr", 8'h00, 8'(ack));
        check("rw", 8'h00, 8'(rw));
        check("selected", 8'h01, 8'(selected));
        check("standby", 8'h00, 8'(standby));
        i_master.put_byte(8'hb3, ack);
        settle();
        check("ack_word", 8'h00, 8'(ack));
        check("word_addr", 8'hb3, word_addr);
        check("page", 8'h16, 8'(page));
        for (int n = 0; n < 3; n++) begin
            i_master.put_byte(8'h96 + 8'(n * 33), ack);
            settle();
            check("ack_data", 8'h00, 8'(ack));
            check("wr_data", 8'h96 + 8'(n * 33), wr_data);
            check("wr_count", 8'(n + 1), wr_cnt);
        end
        i_master.stop_cond();
        settle();
        check("standby", 8'h01, 8'(standby));
        check("bus_idle", 8'h01, 8'(bus_idle));
        // One field wrong at a time: type nibble, then each strap bit.
        for (int k = 0; k < 4; k++) begin
            dev_addr((k == 0) ? 4'h6 : TYPE_ID, (k == 0) ? 3'b101 : 3'b101 ^ (3'b001 << (k - 1)), 1'b0);
            check("ack_mismatch", 8'h01, 8'(ack));
            check("standby", 8'h01, 8'(standby));
            i_master.stop_cond();
        end
        strap = 3'b000;
        settle();
        dev_addr(TYPE_ID, 3'b000, 1'b0);
        check("ack_zero_straps", 8'h00, 8'(ack));
        @(posedge clk_in);
        #1 write_done = 1'b1;
        @(posedge clk_in);
        #1 write_done = 1'b0;
        settle();
        check("standby", 8'h01, 8'(standby));
        i_master.stop_cond();
        strap = 3'b101;
        settle();
        dev_addr(TYPE_ID, 3'b101, 1'b0);
        i_master.put_byte(8'h47, ack);
        dev_addr(TYPE_ID, 3'b101, 1'b1);
        check("ack_read", 8'h00, 8'(ack));
        check("rw", 8'h01, 8'(rw));
        i_master.get_byte(1'b0, b);
        check("rd_byte0", 8'h3c, b);
        i_master.get_byte(1'b1, b);
        settle();
        check("rd_byte1", 8'h8d, b);
        check("standby", 8'h01, 8'(standby));
        check("oe_n", 8'h01, 8'(sda_oe_n));
        check("rd_count", 8'h02, rd_idx);
        i_master.stop_cond();
        // Abort a read while the slave holds the line low, then recover the bus.
        dev_addr(TYPE_ID, 3'b101, 1'b1);
        for (int j = 0; j < 2; j++) begin
            i_master.bit_cycle(1'b1, ack);
        end
        i_master.start_cond();
        i_master.put_byte(8'hff, ack);
        i_master.start_cond();
        i_master.stop_cond();
        settle();
        check("standby", 8'h01, 8'(standby));
        check("oe_n", 8'h01, 8'(sda_oe_n));
        dev_addr(TYPE_ID, 3'b101, 1'b0);
        check("ack_after_recovery", 8'h00, 8'(ack));
        i_master.stop_cond();
        final_report();
    end
endmodule // test_eeprom_bus_slave
